// file: rtl/rssalu_pkg.sv
// package and datapath calculator for the rotate/subtract/skip slice
`timescale 1ns/1ps
`default_nettype none

package rssalu_pkg;
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 4;
    // register offsets
    localparam logic [3:0] REG_CMD = 4'h0;
    localparam logic [3:0] REG_ACC = 4'h1;
    localparam logic [3:0] REG_STATUS = 4'h2;
    localparam logic [3:0] REG_MADDR = 4'h3;
    localparam logic [3:0] REG_MDATA = 4'h4;
    localparam logic [3:0] REG_IMM = 4'h5;
    localparam logic [3:0] REG_BITSEL = 4'h6;
    localparam logic [3:0] REG_INFO = 4'h7;
    // status bit positions
    localparam int unsigned FLAG_C = 0;
    localparam int unsigned FLAG_AC = 1;
    localparam int unsigned FLAG_Z = 2;
    localparam int unsigned FLAG_OV = 3;
    localparam int unsigned FLAG_SC = 4;
    localparam int unsigned FLAG_CZ = 5;
    localparam int unsigned FLAG_CNT = 6;
    // info register bit positions
    localparam int unsigned INFO_BUSY = 0;
    localparam int unsigned INFO_SKIP = 1;
    // constants
    localparam logic [7:0] BYTE_ZERO = 8'h00;
    localparam logic [7:0] BYTE_ONE = 8'h01;
    localparam logic [7:0] BYTE_ONES = 8'hff;
    localparam logic [5:0] FLAGS_NONE = 6'h00;
    localparam logic [5:0] FLAGS_CARRY = 6'h01;
    localparam logic [5:0] FLAGS_ALL = 6'h3f;
    localparam logic [5:0] FLAGS_RESET = 6'h00;
    localparam logic [2:0] BITSEL_RESET = 3'h0;

    typedef enum logic [4:0] {
        OP_NONE = 5'h00,
        OP_ROTATE_LEFT = 5'h01,
        OP_ROTATE_LEFT_TO_WORKING = 5'h02,
        OP_ROTATE_LEFT_THROUGH_CARRY = 5'h03,
        OP_ROTATE_LEFT_THROUGH_CARRY_TO_WORKING = 5'h04,
        OP_ROTATE_RIGHT = 5'h05,
        OP_ROTATE_RIGHT_TO_WORKING = 5'h06,
        OP_ROTATE_RIGHT_THROUGH_CARRY = 5'h07,
        OP_ROTATE_RIGHT_THROUGH_CARRY_TO_WORKING = 5'h08,
        OP_SUBTRACT_WITH_BORROW = 5'h09,
        OP_SUBTRACT_WITH_BORROW_IMM = 5'h0a,
        OP_SUBTRACT_WITH_BORROW_TO_MEMORY = 5'h0b,
        OP_SUBTRACT = 5'h0c,
        OP_SUBTRACT_IMM = 5'h0d,
        OP_SUBTRACT_TO_MEMORY = 5'h0e,
        OP_DECREMENT_SKIP_IF_NULL = 5'h0f,
        OP_DECREMENT_SKIP_IF_NULL_TO_WORKING = 5'h10,
        OP_INCREMENT_SKIP_IF_NULL = 5'h11,
        OP_INCREMENT_SKIP_IF_NULL_TO_WORKING = 5'h12,
        OP_SKIP_IF_NONNULL = 5'h13,
        OP_SKIP_IF_NONNULL_BIT = 5'h14,
        OP_SET_BYTE = 5'h15,
        OP_SET_BIT = 5'h16,
        OP_SWAP_NIBBLES = 5'h17
    } rssalu_op_t;

    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_EXEC = 2'b01,
        ST_DUMMY = 2'b10
    } rssalu_state_t;

    function automatic logic [7:0] bit_mask(input logic [2:0] sel);
        bit_mask = BYTE_ONE << sel;
    endfunction
endpackage

////////////////////////////////////////////////////////////////////////////////

module rssalu_calc (
    // instruction
    input wire logic [4:0] op,
    input wire logic [2:0] bit_sel,
    input wire logic [7:0] imm,
    // operands
    input wire logic [7:0] operand,
    input wire logic [7:0] acc,
    input wire logic [5:0] flags,
    // results
    output logic [7:0] result,
    output logic wr_acc,
    output logic wr_mem,
    output logic [5:0] flags_new,
    output logic [5:0] flags_mask,
    output logic skip
);
    logic [7:0] sub_b;
    logic borrow_in;
    logic with_borrow;
    logic [8:0] diff;
    logic [4:0] low;
    logic [5:0] sub_flags;

    // shared subtractor; borrow-in is the inverted carry for the with-borrow ops, zero for the others
    always_comb begin
        with_borrow = (op == rssalu_pkg::OP_SUBTRACT_WITH_BORROW) ||
                      (op == rssalu_pkg::OP_SUBTRACT_WITH_BORROW_IMM) ||
                      (op == rssalu_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEMORY);
        sub_b = ((op == rssalu_pkg::OP_SUBTRACT_IMM) ||
                 (op == rssalu_pkg::OP_SUBTRACT_WITH_BORROW_IMM)) ? imm : operand;
        borrow_in = with_borrow & ~flags[rssalu_pkg::FLAG_C];
        diff = {1'b0, acc} - {1'b0, sub_b} - {8'h00, borrow_in};
        low = {1'b0, acc[3:0]} - {1'b0, sub_b[3:0]} - {4'h0, borrow_in};
        sub_flags[rssalu_pkg::FLAG_C] = ~diff[8];
        sub_flags[rssalu_pkg::FLAG_AC] = ~low[4];
        sub_flags[rssalu_pkg::FLAG_Z] = (diff[7:0] == rssalu_pkg::BYTE_ZERO);
        sub_flags[rssalu_pkg::FLAG_OV] = (acc[7] ^ sub_b[7]) & (diff[7] ^ acc[7]);
        sub_flags[rssalu_pkg::FLAG_SC] = sub_flags[rssalu_pkg::FLAG_OV] ^ diff[7];
        // chained zero keeps multi-byte compares honest
        sub_flags[rssalu_pkg::FLAG_CZ] = with_borrow ?
            (sub_flags[rssalu_pkg::FLAG_Z] & flags[rssalu_pkg::FLAG_CZ]) : sub_flags[rssalu_pkg::FLAG_Z];
    end

    always_comb begin
        result = operand;
        wr_acc = 1'b0;
        wr_mem = 1'b0;
        flags_new = flags;
        flags_mask = rssalu_pkg::FLAGS_NONE;
        skip = 1'b0;
        case (op)
            rssalu_pkg::OP_ROTATE_LEFT: begin
                result = {operand[6:0], operand[7]};
                wr_mem = 1'b1;
            end
            rssalu_pkg::OP_ROTATE_LEFT_TO_WORKING: begin
                result = {operand[6:0], operand[7]};
                wr_acc = 1'b1;
            end
            rssalu_pkg::OP_ROTATE_LEFT_THROUGH_CARRY,
            rssalu_pkg::OP_ROTATE_LEFT_THROUGH_CARRY_TO_WORKING: begin
                result = {operand[6:0], flags[rssalu_pkg::FLAG_C]};
                flags_new[rssalu_pkg::FLAG_C] = operand[7];
                flags_mask = rssalu_pkg::FLAGS_CARRY;
                wr_mem = (op == rssalu_pkg::OP_ROTATE_LEFT_THROUGH_CARRY);
                wr_acc = (op == rssalu_pkg::OP_ROTATE_LEFT_THROUGH_CARRY_TO_WORKING);
            end
            rssalu_pkg::OP_ROTATE_RIGHT: begin
                result = {operand[0], operand[7:1]};
                wr_mem = 1'b1;
            end
            rssalu_pkg::OP_ROTATE_RIGHT_TO_WORKING: begin
                result = {operand[0], operand[7:1]};
                wr_acc = 1'b1;
            end
            rssalu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY,
            rssalu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_TO_WORKING: begin
                result = {flags[rssalu_pkg::FLAG_C], operand[7:1]};
                flags_new[rssalu_pkg::FLAG_C] = operand[0];
                flags_mask = rssalu_pkg::FLAGS_CARRY;
                wr_mem = (op == rssalu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY);
                wr_acc = (op == rssalu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_TO_WORKING);
            end
            rssalu_pkg::OP_SUBTRACT_WITH_BORROW,
            rssalu_pkg::OP_SUBTRACT_WITH_BORROW_IMM,
            rssalu_pkg::OP_SUBTRACT,
            rssalu_pkg::OP_SUBTRACT_IMM: begin
                result = diff[7:0];
                wr_acc = 1'b1;
                flags_new = sub_flags;
                flags_mask = rssalu_pkg::FLAGS_ALL;
            end
            rssalu_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEMORY,
            rssalu_pkg::OP_SUBTRACT_TO_MEMORY: begin
                result = diff[7:0];
                wr_mem = 1'b1;
                flags_new = sub_flags;
                flags_mask = rssalu_pkg::FLAGS_ALL;
            end
            rssalu_pkg::OP_DECREMENT_SKIP_IF_NULL,
            rssalu_pkg::OP_DECREMENT_SKIP_IF_NULL_TO_WORKING: begin
                result = operand - rssalu_pkg::BYTE_ONE;
                skip = (result == rssalu_pkg::BYTE_ZERO);
                wr_mem = (op == rssalu_pkg::OP_DECREMENT_SKIP_IF_NULL);
                wr_acc = (op == rssalu_pkg::OP_DECREMENT_SKIP_IF_NULL_TO_WORKING);
            end
            rssalu_pkg::OP_INCREMENT_SKIP_IF_NULL,
            rssalu_pkg::OP_INCREMENT_SKIP_IF_NULL_TO_WORKING: begin
                result = operand + rssalu_pkg::BYTE_ONE;
                skip = (result == rssalu_pkg::BYTE_ZERO);
                wr_mem = (op == rssalu_pkg::OP_INCREMENT_SKIP_IF_NULL);
                wr_acc = (op == rssalu_pkg::OP_INCREMENT_SKIP_IF_NULL_TO_WORKING);
            end
            rssalu_pkg::OP_SKIP_IF_NONNULL: begin
                skip = (operand != rssalu_pkg::BYTE_ZERO);
            end
            rssalu_pkg::OP_SKIP_IF_NONNULL_BIT: begin
                skip = ((operand & rssalu_pkg::bit_mask(bit_sel)) != rssalu_pkg::BYTE_ZERO);
            end
            rssalu_pkg::OP_SET_BYTE: begin
                result = rssalu_pkg::BYTE_ONES;
                wr_mem = 1'b1;
            end
            rssalu_pkg::OP_SET_BIT: begin
                result = operand | rssalu_pkg::bit_mask(bit_sel);
                wr_mem = 1'b1;
            end
            rssalu_pkg::OP_SWAP_NIBBLES: begin
                result = {operand[3:0], operand[7:4]};
                wr_mem = 1'b1;
            end
            default: begin
                result = operand;
            end
        endcase
    end
endmodule

`default_nettype wire

// file: rtl/rssalu_top.sv
// rotate/subtract/skip execution slice with its register port and data memory
//
// Local design decisions: strobed register access and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none

module rssalu_top #(
    parameter int unsigned MEM_DEPTH = 16
) (
    // clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // register port
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata,
    // sequencer status
    output logic busy,
    output logic done,
    output logic dummy_slot
);
    localparam int unsigned MEM_AW = (MEM_DEPTH > 1) ? $clog2(MEM_DEPTH) : 1;

    ////////////////////////////////////////////////////////////////////////////
    // architectural state

    logic [7:0] mem [MEM_DEPTH];
    logic [7:0] working_register;
    logic [5:0] flags;
    logic [7:0] maddr;
    logic [7:0] imm;
    logic [2:0] bit_sel;
    logic [4:0] op;
    logic last_skip;
    rssalu_pkg::rssalu_state_t state;
    rssalu_pkg::rssalu_state_t next_state;

    logic [MEM_AW-1:0] mem_index;
    logic [7:0] operand;
    logic [7:0] result;
    logic wr_acc;
    logic wr_mem;
    logic [5:0] flags_new;
    logic [5:0] flags_mask;
    logic skip;
    logic exec;
    logic cmd_write;

    assign mem_index = maddr[MEM_AW-1:0];
    assign operand = mem[mem_index];
    assign exec = (state == rssalu_pkg::ST_EXEC);
    // commands are ignored while a previous one is still in flight
    assign cmd_write = wr && (addr == rssalu_pkg::REG_CMD) && (state == rssalu_pkg::ST_IDLE);

    ////////////////////////////////////////////////////////////////////////////
    // datapath

    rssalu_calc u_calc (
        .op(op),
        .bit_sel(bit_sel),
        .imm(imm),
        .operand(operand),
        .acc(working_register),
        .flags(flags),
        .result(result),
        .wr_acc(wr_acc),
        .wr_mem(wr_mem),
        .flags_new(flags_new),
        .flags_mask(flags_mask),
        .skip(skip)
    );

    ////////////////////////////////////////////////////////////////////////////
    // sequencing

    always_comb begin
        next_state = state;
        case (state)
            rssalu_pkg::ST_IDLE: begin
                if (cmd_write) begin
                    next_state = rssalu_pkg::ST_EXEC;
                end
            end
            rssalu_pkg::ST_EXEC: begin
                next_state = skip ? rssalu_pkg::ST_DUMMY : rssalu_pkg::ST_IDLE;
            end
            rssalu_pkg::ST_DUMMY: begin
                next_state = rssalu_pkg::ST_IDLE;
            end
            default: begin
                next_state = rssalu_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            state <= rssalu_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            busy <= 1'b0;
            done <= 1'b0;
            dummy_slot <= 1'b0;
            last_skip <= 1'b0;
        end else begin
            busy <= (next_state != rssalu_pkg::ST_IDLE);
            done <= exec;
            dummy_slot <= (next_state == rssalu_pkg::ST_DUMMY);
            if (exec) begin
                last_skip <= skip;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // command and operand registers

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            op <= rssalu_pkg::OP_NONE;
        end else if (cmd_write) begin
            op <= wdata[4:0];
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            maddr <= rssalu_pkg::BYTE_ZERO;
            imm <= rssalu_pkg::BYTE_ZERO;
            bit_sel <= rssalu_pkg::BITSEL_RESET;
        end else if (wr && !busy) begin
            if (addr == rssalu_pkg::REG_MADDR) begin
                maddr <= wdata;
            end
            if (addr == rssalu_pkg::REG_IMM) begin
                imm <= wdata;
            end
            if (addr == rssalu_pkg::REG_BITSEL) begin
                bit_sel <= wdata[2:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // accumulator, flags and memory; execution wins over a bus write

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            working_register <= rssalu_pkg::BYTE_ZERO;
        end else if (exec && wr_acc) begin
            working_register <= result;
        end else if (wr && !busy && addr == rssalu_pkg::REG_ACC) begin
            working_register <= wdata;
        end
    end

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            flags <= rssalu_pkg::FLAGS_RESET;
        end else if (exec) begin
            flags <= (flags & ~flags_mask) | (flags_new & flags_mask);
        end else if (wr && !busy && addr == rssalu_pkg::REG_STATUS) begin
            flags <= wdata[rssalu_pkg::FLAG_CNT-1:0];
        end
    end

    // data memory has no reset; software initialises what it uses
    always_ff @(posedge mclk) begin
        if (exec && wr_mem) begin
            mem[mem_index] <= result;
        end else if (wr && !busy && addr == rssalu_pkg::REG_MDATA) begin
            mem[mem_index] <= wdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // read port: data one cycle after the strobe, zero otherwise

    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= rssalu_pkg::BYTE_ZERO;
        end else if (rd) begin
            case (addr)
                rssalu_pkg::REG_CMD: rdata <= {3'h0, op};
                rssalu_pkg::REG_ACC: rdata <= working_register;
                rssalu_pkg::REG_STATUS: rdata <= {2'h0, flags};
                rssalu_pkg::REG_MADDR: rdata <= maddr;
                rssalu_pkg::REG_MDATA: rdata <= operand;
                rssalu_pkg::REG_IMM: rdata <= imm;
                rssalu_pkg::REG_BITSEL: rdata <= {5'h00, bit_sel};
                rssalu_pkg::REG_INFO: rdata <= {6'h00, last_skip, busy};
                default: rdata <= rssalu_pkg::BYTE_ZERO;
            endcase
        end else begin
            rdata <= rssalu_pkg::BYTE_ZERO;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks

    a_rotl_inplace: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_ROTATE_LEFT) |->
        (result == {operand[6:0], operand[7]}) && wr_mem && !wr_acc && flags_mask == rssalu_pkg::FLAGS_NONE)
        else $error("rotate left in place wrong");

    a_rotl_working: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_ROTATE_LEFT_TO_WORKING) |=>
        (working_register == {$past(operand[6:0]), $past(operand[7])}) && $stable(flags))
        else $error("rotate left to accumulator wrong");

    a_rotl_carry: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_ROTATE_LEFT_THROUGH_CARRY) |->
        ##1 (flags[rssalu_pkg::FLAG_C] == $past(operand[7])) && ($past(flags[5:1]) == flags[5:1]))
        else $error("rotate left through carry wrong");

    a_rotl_carry_acc: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_ROTATE_LEFT_THROUGH_CARRY_TO_WORKING) |->
        (result == {operand[6:0], flags[rssalu_pkg::FLAG_C]}) && !wr_mem && wr_acc)
        else $error("rotate left through carry to accumulator wrong");

    a_rotr_inplace: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_ROTATE_RIGHT) |=>
        (mem[$past(mem_index)] == {$past(operand[0]), $past(operand[7:1])}) && $stable(flags))
        else $error("rotate right in place wrong");

    a_rotr_working: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_ROTATE_RIGHT_TO_WORKING) |->
        (result == {operand[0], operand[7:1]}) && wr_acc && !wr_mem)
        else $error("rotate right to accumulator wrong");

    a_rotr_carry: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY) |->
        (result == {flags[rssalu_pkg::FLAG_C], operand[7:1]}) && wr_mem)
        else $error("rotate right through carry wrong");

    a_rotr_carry_acc: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_ROTATE_RIGHT_THROUGH_CARRY_TO_WORKING) |=>
        flags[rssalu_pkg::FLAG_C] == $past(operand[0]))
        else $error("carry after right rotate wrong");

    a_sub_borrow: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_SUBTRACT_WITH_BORROW) |->
        (result == working_register - operand - {7'h00, ~flags[rssalu_pkg::FLAG_C]}) && wr_acc)
        else $error("subtract with borrow result wrong");

    a_sub_carry: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_SUBTRACT) |->
        (flags_new[rssalu_pkg::FLAG_C] == (working_register >= operand)) && flags_mask == rssalu_pkg::FLAGS_ALL)
        else $error("subtract carry wrong");

    a_sub_memdest: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_SUBTRACT_WITH_BORROW_TO_MEMORY) |=> $stable(working_register))
        else $error("memory subtract touched accumulator");

    a_dec_skip: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_DECREMENT_SKIP_IF_NULL) |->
        (skip == (operand == rssalu_pkg::BYTE_ONE)) && flags_mask == rssalu_pkg::FLAGS_NONE)
        else $error("decrement skip wrong");

    a_inc_skip: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_INCREMENT_SKIP_IF_NULL_TO_WORKING) |->
        (skip == (operand == rssalu_pkg::BYTE_ONES)) && wr_acc && !wr_mem)
        else $error("increment skip wrong");

    a_skip_slot: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && skip) |=> dummy_slot && busy ##1 !dummy_slot && !busy)
        else $error("skip slot timing wrong");

    a_noskip_slot: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && !skip) |=> !dummy_slot && !busy && done)
        else $error("unskipped instruction took an extra slot");

    a_set_bit: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_SET_BIT) |->
        (result == (operand | rssalu_pkg::bit_mask(bit_sel))) && flags_mask == rssalu_pkg::FLAGS_NONE)
        else $error("bit set wrong");

    a_swap_nib: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_SWAP_NIBBLES) |->
        (result == {operand[3:0], operand[7:4]}) && wr_mem)
        else $error("nibble swap wrong");

    a_sub_imm: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_SUBTRACT_WITH_BORROW_IMM) |->
        (result == working_register - imm - {7'h00, ~flags[rssalu_pkg::FLAG_C]})
        && wr_acc)
        else $error("immediate subtract wrong");

    a_sub_zero: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op >= rssalu_pkg::OP_SUBTRACT_WITH_BORROW
        && op <= rssalu_pkg::OP_SUBTRACT_TO_MEMORY) |=>
        flags[rssalu_pkg::FLAG_Z] == ($past(result) == rssalu_pkg::BYTE_ZERO))
        else $error("subtract zero flag wrong");

    a_dec_working: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_DECREMENT_SKIP_IF_NULL_TO_WORKING) |=>
        (working_register == $past(operand) - rssalu_pkg::BYTE_ONE)
        && (last_skip == (working_register == rssalu_pkg::BYTE_ZERO)) && $stable(flags))
        else $error("decrement to accumulator wrong");

    a_inc_inplace: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_INCREMENT_SKIP_IF_NULL) |=>
        (mem[$past(mem_index)] == $past(operand) + rssalu_pkg::BYTE_ONE)
        && (last_skip == (mem[$past(mem_index)] == rssalu_pkg::BYTE_ZERO)))
        else $error("increment in place wrong");

    a_set_byte: assert property (@(posedge mclk) disable iff (!reset_n)
        (exec && op == rssalu_pkg::OP_SET_BYTE) |=>
        (mem[$past(mem_index)] == rssalu_pkg::BYTE_ONES)
        && $stable(flags))
        else $error("byte set wrong");
endmodule

`default_nettype wire

// file: tb/rssalu_seq_model.sv
// register-port master standing in for the fetch and sequencing logic
`timescale 1ns/1ps
`default_nettype none
module rssalu_seq_model (
    // clock
    input wire logic mclk,
    // register port
    output logic [3:0] addr,
    output logic [7:0] wdata,
    output logic wr,
    output logic rd,
    input wire logic [7:0] rdata
);
    initial begin
        addr = 4'h0;
        wdata = 8'h00;
        wr = 1'b0;
        rd = 1'b0;
    end
    // strobes drop after their edge, so two accesses are two cycles apart
    task automatic put(input logic [3:0] a, input logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge mclk);
        wr <= 1'b0;
    endtask
    task automatic get(input logic [3:0] a, output logic [7:0] d);
        @(posedge mclk);
        addr <= a;
        rd <= 1'b1;
        @(posedge mclk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
endmodule
`default_nettype wire

// file: tb/tb_top.sv
// self-checking bench for the rotate/subtract/skip slice
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic mclk, reset_n, wr, rd, busy, dummy_slot, done;
    logic [3:0] addr;
    logic [7:0] wdata, rdata;
    int n_errors = 0;
    int check_count = 0;
    rssalu_seq_model u_seq (.mclk(mclk), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    rssalu_top #(.MEM_DEPTH(16)) u_dut (.mclk(mclk), .reset_n(reset_n), .addr(addr), .wdata(wdata), .wr(wr),
        .rd(rd), .rdata(rdata), .busy(busy), .done(done), .dummy_slot(dummy_slot));
    ////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic run(input logic [4:0] op, input logic [7:0] m, a, st, input logic [2:0] bs);
        logic [7:0] em, ea, es, g, s, nd;
        logic [8:0] d;
        logic [4:0] lo;
        logic sk, dm, c, b, z, ov;
        int n;
        {em, ea, es, nd, sk, dm, c, n} = {m, a, st, 8'h00, 1'b0, 1'b0, st[0], 32'h0000_0000};
        case (op)
            5'h01: em = {m[6:0], m[7]};
            5'h02: ea = {m[6:0], m[7]};
            5'h03: {es[0], em} = {m, c};
            5'h04: {es[0], ea} = {m, c};
            5'h05: em = {m[0], m[7:1]};
            5'h06: ea = {m[0], m[7:1]};
            5'h07: {em, es[0]} = {c, m};
            5'h08: {ea, es[0]} = {c, m};
            5'h0f: {em, sk} = {m - 8'h01, m == 8'h01};
            5'h10: {ea, sk} = {m - 8'h01, m == 8'h01};
            5'h11: {em, sk} = {m + 8'h01, m == 8'hff};
            5'h12: {ea, sk} = {m + 8'h01, m == 8'hff};
            5'h13: sk = m != 8'h00;
            5'h14: sk = m[bs];
            5'h15: em = 8'hff;
            5'h16: em = m | (8'h01 << bs);
            5'h17: em = {m[3:0], m[7:4]};
            5'h09, 5'h0a, 5'h0b, 5'h0c, 5'h0d, 5'h0e: begin
                s = m;
                b = (op < 5'h0c) ? ~c : 1'b0;
                d = {1'b0, a} - {1'b0, s} - {8'h00, b};
                lo = {1'b0, a[3:0]} - {1'b0, s[3:0]} - {4'h0, b};
                z = d[7:0] == 8'h00;
                ov = (a[7] ^ s[7]) & (a[7] ^ d[7]);
                es = {2'b00, (op < 5'h0c) ? z & st[5] : z, ov ^ d[7], ov, z, ~lo[4], ~d[8]};
                if (op == 5'h0b || op == 5'h0e) em = d[7:0]; else ea = d[7:0];
            end
            default: ;
        endcase
        u_seq.put(rssalu_pkg::REG_MDATA, m);
        u_seq.put(rssalu_pkg::REG_ACC, a);
        u_seq.put(rssalu_pkg::REG_STATUS, st);
        u_seq.put(rssalu_pkg::REG_IMM, m);
        u_seq.put(rssalu_pkg::REG_BITSEL, {5'h00, bs});
        u_seq.put(rssalu_pkg::REG_CMD, {3'h0, op});
        repeat (6) begin
            #1;
            nd = nd + {7'h00, done};
            if (busy !== 1'b1) break;
            n++;
            dm = dm | dummy_slot;
            @(posedge mclk);
        end
        chk("cycles", {7'h00, sk} + 8'h01, 8'(n));
        chk("dummy", {7'h00, sk}, {7'h00, dm});
        chk("done", 8'h01, nd);
        u_seq.get(rssalu_pkg::REG_ACC, g);
        chk("acc", ea, g);
        u_seq.get(rssalu_pkg::REG_STATUS, g);
        chk("status", es, g);
        u_seq.get(rssalu_pkg::REG_MDATA, g);
        chk("mem", em, g);
        u_seq.get(rssalu_pkg::REG_INFO, g);
        chk("info", {6'h00, sk, 1'b0}, g);
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task automatic t_rotate();
        for (int i = 0; i < 16; i++) begin
            run(5'(1 + i / 2), i[0] ? 8'h4e : 8'h81, 8'h3c, i[0] ? 8'h3f : 8'h00, 3'h0);
        end
        $display("test rotate done");
    endtask
    // negative with carry set, signed wrap with borrow, zero with chained null
    task automatic t_subtract();
        logic [7:0] av[3] = '{8'h50, 8'h80, 8'h37};
        logic [7:0] mv[3] = '{8'h70, 8'h01, 8'h37};
        logic [7:0] sv[3] = '{8'h3f, 8'h00, 8'h21};
        for (int i = 0; i < 18; i++) begin
            run(5'(9 + i % 6), mv[i / 6], av[i / 6], sv[i / 6], 3'h0);
        end
        $display("test subtract done");
    endtask
    task automatic t_skip();
        logic [7:0] mv[4] = '{8'h01, 8'hff, 8'h00, 8'h80};
        for (int i = 0; i < 24; i++) begin
            run(5'(15 + i % 6), mv[i / 6], 8'h5a, 8'h21, 3'h7);
        end
        $display("test skip done");
    endtask
    task automatic t_set_swap();
        logic [7:0] g;
        for (int i = 0; i < 6; i++) begin
            run(5'(21 + i % 3), i < 3 ? 8'h5a : 8'h00, 8'h11, 8'h3f, i < 3 ? 3'h2 : 3'h7);
        end
        run(5'h18, 8'h96, 8'h69, 8'h15, 3'h0);
        u_seq.get(4'h9, g);
        chk("unmapped", 8'h00, g);
        $display("test set swap done");
    endtask
    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end
    // about 70 instructions of some 22 cycles each fit well inside this span
    initial begin
        repeat (20000) @(posedge mclk);
        n_errors++;
        tally_and_finish();
    end
    initial begin
        logic [7:0] g;
        reset_n = 1'b0;
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        u_seq.get(rssalu_pkg::REG_STATUS, g);
        chk("reset status", 8'h00, g);
        t_rotate();
        t_subtract();
        t_skip();
        t_set_swap();
        tally_and_finish();
    end
endmodule
`default_nettype wire
